// ### verilog/tec_map.vh
`ifndef TEC_MAP_VH
`define TEC_MAP_VH

// Register indices on the plain register port
`define TEC_ADDR_W        4
`define TEC_A_CTL0        4'h0
`define TEC_A_CTL1        4'h1
`define TEC_A_OUTCTL      4'h2
`define TEC_A_EDGE_A      4'h3
`define TEC_A_EDGE_B      4'h4
`define TEC_A_NFC_A       4'h5
`define TEC_A_NFC_B       4'h6
`define TEC_A_CCR_A       4'h7
`define TEC_A_CCR_B       4'h8
`define TEC_A_CNT         4'h9
`define TEC_A_STAT        4'ha
`define TEC_A_MASK        4'hb

// Control register 0
`define TEC_RUN_BIT       7
`define TEC_CKS_MSB       2
`define TEC_CTL0_W        8
`define TEC_CTL0_RST      8'h00

// Control register 1 (mode bits)
`define TEC_MD_EVT        0
`define TEC_MD_CAPA       1
`define TEC_MD_CAPB       2
`define TEC_MD_TRIG       3
`define TEC_CTL1_W        4
`define TEC_CTL1_RST      4'h0

// Output control
`define TEC_OC_ENA        0
`define TEC_OC_LVA        1
`define TEC_OC_ENB        2
`define TEC_OC_LVB        3
`define TEC_OC_W          4
`define TEC_OC_RST        4'h0

// Edge select: [1:0] capture edge, [3:2] event/trigger edge
`define TEC_EDGE_W        4
`define TEC_EDGE_RST      4'h0
`define TEC_EDGE_NONE     2'h0
`define TEC_EDGE_RISE     2'h1
`define TEC_EDGE_FALL     2'h2
`define TEC_EDGE_BOTH     2'h3

// Noise filter control
`define TEC_NF_EN         0
`define TEC_NFC_RST       1'b0

// Counter and compare values
`define TEC_CNT_IDLE      16'hffff
`define TEC_CNT_ZERO      16'h0000
`define TEC_CNT_ONE       16'h0001
`define TEC_CCR_RST       16'h0000

// Status / mask bits
`define TEC_ST_CCA        0
`define TEC_ST_CCB        1
`define TEC_ST_OVF        2
`define TEC_ST_W          3
`define TEC_ST_RST        3'h0

`endif

// ### verilog/tec_pin_cond.v
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_pin_cond #(
   parameter FILT_LEN = 3,
   parameter FILT_W   = 2
) (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Pin and filter control
   input  wire pin_i,
   input  wire filt_en_i,
   // Edge pulses
   output wire raw_rise_o,
   output wire raw_fall_o,
   output wire rise_o,
   output wire fall_o
);

   reg              s1_q;
   reg              s2_q;
   reg              s3_q;
   reg              flt_q;
   reg              flt_prev_q;
   reg [FILT_W-1:0] cnt_q;

   localparam [FILT_W-1:0] LAST = FILT_LEN - 1;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q       <= 1'b0;
         s2_q       <= 1'b0;
         s3_q       <= 1'b0;
         flt_q      <= 1'b0;
         flt_prev_q <= 1'b0;
         cnt_q      <= {FILT_W{1'b0}};
      end else begin
         s1_q       <= pin_i;
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         flt_prev_q <= flt_q;
         // Level must hold FILT_LEN samples before it is believed
         if (s2_q != flt_q) begin
            if (cnt_q == LAST) begin
               flt_q <= s2_q;
               cnt_q <= {FILT_W{1'b0}};
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end else begin
            cnt_q <= {FILT_W{1'b0}};
         end
      end
   end

   assign raw_rise_o = s2_q & ~s3_q;
   assign raw_fall_o = ~s2_q & s3_q;
   assign rise_o = filt_en_i ? (flt_q & ~flt_prev_q) : raw_rise_o;
   assign fall_o = filt_en_i ? (~flt_q & flt_prev_q) : raw_fall_o;

endmodule

// ### verilog/tec_prescale.v
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_prescale #(
   parameter DIV_W = 7
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Control
   input  wire       run_i,
   input  wire [2:0] sel_i,
   // One-cycle count enable
   output wire       tick_o
);

   reg  [DIV_W-1:0] cnt_q;
   wire [DIV_W-1:0] mask;

   // Divide by two to the power sel: tick when the low sel bits are all ones
   assign mask = ~({DIV_W{1'b1}} << sel_i);
   assign tick_o = run_i & ((cnt_q & mask) == mask);

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= {DIV_W{1'b0}};
      end else if (!run_i) begin
         cnt_q <= {DIV_W{1'b0}};
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule

// ### verilog/tec_core.v
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_core #(
   parameter DATA_W   = 16,
   parameter DIV_W    = 7,
   parameter FILT_LEN = 3,
   parameter FILT_W   = 2
) (
   // Clock and reset
   input  wire                   clk_i,
   input  wire                   rst_i,
   // Register port
   input  wire [`TEC_ADDR_W-1:0] addr_i,
   input  wire [DATA_W-1:0]      wdata_i,
   input  wire                   wr_i,
   input  wire                   rd_i,
   output reg  [DATA_W-1:0]      rdata_o,
   // Timer pins
   input  wire                   timer_input_a_i,
   input  wire                   timer_input_b_i,
   output reg                    timer_output_a_o,
   output reg                    timer_output_b_o,
   // Interrupts
   output reg                    match_irq_a_o,
   output reg                    match_irq_b_o,
   output reg                    irq_o
);

   reg  [`TEC_CTL0_W-1:0] ctl0_q;
   reg  [`TEC_CTL1_W-1:0] ctl1_q;
   reg  [`TEC_OC_W-1:0]   outctl_q;
   reg  [`TEC_EDGE_W-1:0] edge_a_q;
   reg  [`TEC_EDGE_W-1:0] edge_b_q;
   reg                    nfc_a_q;
   reg                    nfc_b_q;
   reg  [15:0]            ccr_a_q;
   reg  [15:0]            ccr_b_q;
   reg  [15:0]            buf_a_q;
   reg  [15:0]            buf_b_q;
   reg  [15:0]            cnt_q;
   reg                    armed_q;
   reg                    started_q;
   reg                    tog_a_q;
   reg                    tog_b_q;
   reg  [`TEC_ST_W-1:0]   stat_q;
   reg  [`TEC_ST_W-1:0]   mask_q;
   reg  [`TEC_ST_W-1:0]   stat_d;
   reg  [DATA_W-1:0]      rmux;

   wire                   run;
   wire                   md_evt;
   wire                   cap_a;
   wire                   cap_b;
   wire                   md_trig;
   wire                   tick_int;
   wire                   ev_hit;
   wire                   cnt_tick;
   wire [15:0]            cnt_nxt;
   wire                   match_a;
   wire                   match_b;
   wire                   capt_a;
   wire                   capt_b;
   wire                   ovf;
   wire                   a_raw_r;
   wire                   a_raw_f;
   wire                   a_r;
   wire                   a_f;
   wire                   b_r;
   wire                   b_f;
   wire                   wr_ccr_a;
   wire                   wr_ccr_b;
   wire [`TEC_ST_W-1:0]   st_set;
   wire [`TEC_ST_W-1:0]   st_clr;

   function edge_hit;
      input [1:0] sel;
      input       r;
      input       f;
      begin
         case (sel)
            `TEC_EDGE_RISE: edge_hit = r;
            `TEC_EDGE_FALL: edge_hit = f;
            `TEC_EDGE_BOTH: edge_hit = r | f;
            default:        edge_hit = 1'b0;
         endcase
      end
   endfunction

   function reg_hit;
      input                   wr;
      input [`TEC_ADDR_W-1:0] addr;
      input [`TEC_ADDR_W-1:0] target;
      begin
         reg_hit = wr & (addr == target);
      end
   endfunction

   assign run     = ctl0_q[`TEC_RUN_BIT];
   assign md_evt  = ctl1_q[`TEC_MD_EVT];
   assign cap_a   = ctl1_q[`TEC_MD_CAPA];
   assign cap_b   = ctl1_q[`TEC_MD_CAPB];
   assign md_trig = ctl1_q[`TEC_MD_TRIG];

   tec_prescale #(
      .DIV_W (DIV_W)
   ) u_pre (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (run),
      .sel_i  (ctl0_q[`TEC_CKS_MSB:0]),
      .tick_o (tick_int)
   );

   // Filter only engaged when the pin feeds a capture
   tec_pin_cond #(
      .FILT_LEN (FILT_LEN),
      .FILT_W   (FILT_W)
   ) u_pin_a (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (timer_input_a_i),
      .filt_en_i  (nfc_a_q & cap_a),
      .raw_rise_o (a_raw_r),
      .raw_fall_o (a_raw_f),
      .rise_o     (a_r),
      .fall_o     (a_f)
   );

   tec_pin_cond #(
      .FILT_LEN (FILT_LEN),
      .FILT_W   (FILT_W)
   ) u_pin_b (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (timer_input_b_i),
      .filt_en_i  (nfc_b_q & cap_b),
      .raw_rise_o (),
      .raw_fall_o (),
      .rise_o     (b_r),
      .fall_o     (b_f)
   );

   // Event and trigger use the unfiltered edges of input A
   assign ev_hit = edge_hit(edge_a_q[3:2], a_raw_r, a_raw_f);
   assign capt_a = run & cap_a & edge_hit(edge_a_q[1:0], a_r, a_f);
   assign capt_b = run & cap_b & edge_hit(edge_b_q[1:0], b_r, b_f);

   assign cnt_tick = run & armed_q & (md_evt ? ev_hit : tick_int);
   assign cnt_nxt  = cnt_q + `TEC_CNT_ONE;

   // Compare against the value the counter is about to take
   assign match_a = cnt_tick & ~cap_a & (cnt_nxt == buf_a_q);
   assign match_b = cnt_tick & ~cap_b & (cnt_nxt == buf_b_q);
   assign ovf     = cnt_tick & started_q & (cnt_q == `TEC_CNT_IDLE);

   assign wr_ccr_a = reg_hit(wr_i, addr_i, `TEC_A_CCR_A);
   assign wr_ccr_b = reg_hit(wr_i, addr_i, `TEC_A_CCR_B);

   // Control registers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl0_q   <= `TEC_CTL0_RST;
         ctl1_q   <= `TEC_CTL1_RST;
         outctl_q <= `TEC_OC_RST;
         edge_a_q <= `TEC_EDGE_RST;
         edge_b_q <= `TEC_EDGE_RST;
         nfc_a_q  <= `TEC_NFC_RST;
         nfc_b_q  <= `TEC_NFC_RST;
         mask_q   <= `TEC_ST_RST;
      end else if (wr_i) begin
         case (addr_i)
            `TEC_A_CTL0:   ctl0_q   <= wdata_i[`TEC_CTL0_W-1:0];
            `TEC_A_CTL1:   ctl1_q   <= wdata_i[`TEC_CTL1_W-1:0];
            `TEC_A_OUTCTL: outctl_q <= wdata_i[`TEC_OC_W-1:0];
            `TEC_A_EDGE_A: edge_a_q <= wdata_i[`TEC_EDGE_W-1:0];
            `TEC_A_EDGE_B: edge_b_q <= wdata_i[`TEC_EDGE_W-1:0];
            `TEC_A_NFC_A:  nfc_a_q  <= wdata_i[`TEC_NF_EN];
            `TEC_A_NFC_B:  nfc_b_q  <= wdata_i[`TEC_NF_EN];
            `TEC_A_MASK:   mask_q   <= wdata_i[`TEC_ST_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Capture/compare registers and hidden compare buffers
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ccr_a_q <= `TEC_CCR_RST;
         ccr_b_q <= `TEC_CCR_RST;
         buf_a_q <= `TEC_CCR_RST;
         buf_b_q <= `TEC_CCR_RST;
      end else begin
         // Hardware capture wins over a software write in the same cycle
         if (capt_a) begin
            ccr_a_q <= cnt_q;
         end else if (wr_ccr_a) begin
            ccr_a_q <= wdata_i[15:0];
         end
         if (capt_b) begin
            ccr_b_q <= cnt_q;
         end else if (wr_ccr_b) begin
            ccr_b_q <= wdata_i[15:0];
         end
         if (wr_ccr_a && !cap_a) begin
            buf_a_q <= wdata_i[15:0];
         end
         if (wr_ccr_b && !cap_b) begin
            buf_b_q <= wdata_i[15:0];
         end
      end
   end

   // Counter, trigger arming and first-step tracking
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q     <= `TEC_CNT_IDLE;
         armed_q   <= 1'b0;
         started_q <= 1'b0;
      end else if (!run) begin
         cnt_q     <= `TEC_CNT_IDLE;
         armed_q   <= 1'b0;
         started_q <= 1'b0;
      end else begin
         if (!md_trig || ev_hit) begin
            armed_q <= 1'b1;
         end
         if (cnt_tick) begin
            cnt_q     <= cnt_nxt;
            started_q <= 1'b1;
         end
      end
   end

   // Output controller: each match toggles its pin phase
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tog_a_q          <= 1'b0;
         tog_b_q          <= 1'b0;
         timer_output_a_o <= 1'b0;
         timer_output_b_o <= 1'b0;
      end else begin
         if (!run) begin
            tog_a_q <= 1'b0;
            tog_b_q <= 1'b0;
         end else begin
            tog_a_q <= tog_a_q ^ match_a;
            tog_b_q <= tog_b_q ^ match_b;
         end
         timer_output_a_o <= outctl_q[`TEC_OC_ENA] &
                             (outctl_q[`TEC_OC_LVA] ^ tog_a_q);
         timer_output_b_o <= outctl_q[`TEC_OC_ENB] &
                             (outctl_q[`TEC_OC_LVB] ^ tog_b_q);
      end
   end

   // Sticky status; a new event beats a simultaneous clear
   assign st_set = {ovf, match_b | capt_b, match_a | capt_a};
   assign st_clr = reg_hit(wr_i, addr_i, `TEC_A_STAT) ?
                   wdata_i[`TEC_ST_W-1:0] : `TEC_ST_RST;

   always @* begin
      stat_d = (stat_q & ~st_clr) | st_set;
   end

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stat_q        <= `TEC_ST_RST;
         irq_o         <= 1'b0;
         match_irq_a_o <= 1'b0;
         match_irq_b_o <= 1'b0;
      end else begin
         stat_q        <= stat_d;
         irq_o         <= |(stat_d & mask_q);
         match_irq_a_o <= match_a;
         match_irq_b_o <= match_b;
      end
   end

   // Read multiplexer; compare buffers deliberately have no address
   always @* begin
      rmux = {DATA_W{1'b0}};
      case (addr_i)
         `TEC_A_CTL0:   rmux[`TEC_CTL0_W-1:0] = ctl0_q;
         `TEC_A_CTL1:   rmux[`TEC_CTL1_W-1:0] = ctl1_q;
         `TEC_A_OUTCTL: rmux[`TEC_OC_W-1:0]   = outctl_q;
         `TEC_A_EDGE_A: rmux[`TEC_EDGE_W-1:0] = edge_a_q;
         `TEC_A_EDGE_B: rmux[`TEC_EDGE_W-1:0] = edge_b_q;
         `TEC_A_NFC_A:  rmux[`TEC_NF_EN]      = nfc_a_q;
         `TEC_A_NFC_B:  rmux[`TEC_NF_EN]      = nfc_b_q;
         `TEC_A_CCR_A:  rmux[15:0]            = ccr_a_q;
         `TEC_A_CCR_B:  rmux[15:0]            = ccr_b_q;
         `TEC_A_CNT:    rmux[15:0]            = run ? cnt_q :
                                                `TEC_CNT_ZERO;
         `TEC_A_STAT:   rmux[`TEC_ST_W-1:0]   = stat_q;
         `TEC_A_MASK:   rmux[`TEC_ST_W-1:0]   = mask_q;
         default:       rmux = {DATA_W{1'b0}};
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= {DATA_W{1'b0}};
      end else if (rd_i) begin
         rdata_o <= rmux;
      end else begin
         rdata_o <= {DATA_W{1'b0}};
      end
   end

endmodule

// ### tb/tec_asserts.sv
`timescale 1ns/100ps
`include "tec_map.vh"
module tec_asserts #(
   parameter DATA_W = 16
) (
   // Clock and reset
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   // Register port
   input wire logic [`TEC_ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0]      wdata_i,
   input wire logic                   wr_i,
   input wire logic                   rd_i,
   input wire logic [DATA_W-1:0]      rdata_o,
   // Pins and interrupts
   input wire logic                   timer_output_a_o,
   input wire logic                   match_irq_a_o,
   input wire logic                   match_irq_b_o,
   input wire logic                   irq_o
);
   // Shadows of software settings, rebuilt from the write strobes, and read-slot flags from the read strobe
   logic       run_q;
   logic       en_a_q;
   logic       cnt_rd_q;
   logic       bad_rd_q;
   logic [2:0] mask_q;

   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_q    <= 1'b0;
         en_a_q   <= 1'b0;
         cnt_rd_q <= 1'b0;
         bad_rd_q <= 1'b0;
         mask_q   <= 3'h0;
      end else begin
         if (wr_i && addr_i == `TEC_A_CTL0)
            run_q <= wdata_i[`TEC_RUN_BIT];
         if (wr_i && addr_i == `TEC_A_OUTCTL)
            en_a_q <= wdata_i[`TEC_OC_ENA];
         if (wr_i && addr_i == `TEC_A_MASK)
            mask_q <= wdata_i[2:0];
         cnt_rd_q <= rd_i && addr_i == `TEC_A_CNT && !run_q;
         bad_rd_q <= rd_i && addr_i > `TEC_A_MASK;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read slot");

   property p_unmapped;
      bad_rd_q |-> rdata_o == '0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");

   property p_cnt_stop;
      cnt_rd_q |-> rdata_o == '0;
   endproperty
   a_cnt_stop: assert property (p_cnt_stop)
      else $error("stopped counter read not zero");

   property p_rst_clean;
      $fell(rst_i) |-> !irq_o && !timer_output_a_o && rdata_o == '0;
   endproperty
   a_rst_clean: assert property (p_rst_clean)
      else $error("outputs not idle after reset");

   // Two settled cycles: a tick on the stopping edge may still report
   property p_stop_quiet;
      !run_q && !$past(run_q) && !$past(run_q, 2)
         |-> !match_irq_a_o && !match_irq_b_o;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("match pulse while stopped");

   property p_irq_a;
      match_irq_a_o && mask_q[`TEC_ST_CCA] && $past(mask_q[`TEC_ST_CCA])
         |-> irq_o;
   endproperty
   a_irq_a: assert property (p_irq_a)
      else $error("unmasked match did not raise interrupt");

   property p_irq_off;
      mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt high with all sources masked");

   property p_out_off;
      !en_a_q && !$past(en_a_q) && !$past(en_a_q, 2) |-> !timer_output_a_o;
   endproperty
   a_out_off: assert property (p_out_off)
      else $error("disabled output pin driven high");
endmodule

bind tec_core tec_asserts #(.DATA_W(DATA_W)) u_asserts (
   .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .timer_output_a_o, .match_irq_a_o, .match_irq_b_o, .irq_o
);

// ### tb/tec_pin_drv.sv
`timescale 1ns/100ps
module tec_pin_drv (
   // Clock
   input  wire logic clk_i,
   // Timer input pins
   output logic      pin_a_o,
   output logic      pin_b_o
);
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end

   // Hold counted in clocks; short holds model glitches on purpose
   task automatic drive(input logic a, input logic b, input int hold);
      @(posedge clk_i);
      pin_a_o <= a;
      pin_b_o <= b;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`include "tec_map.vh"
module tb;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic [3:0]  addr_i      = 4'h0;
   logic [15:0] wdata_i     = 16'h0000;
   logic        wr_i        = 1'b0;
   logic        rd_i        = 1'b0;
   wire  [15:0] rdata_o;
   wire         pin_a;
   wire         pin_b;
   wire         out_a;
   wire         out_b;
   wire         hit_a;
   wire         hit_b;
   wire         irq_o;
   int          errors      = 0;
   int          comparisons = 0;
   int          n;
   logic [15:0] c0;
   logic [15:0] c1;

   always #10 clk_i = ~clk_i;

   tec_core dut (
      .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .timer_input_a_i(pin_a), .timer_input_b_i(pin_b),
      .timer_output_a_o(out_a), .timer_output_b_o(out_b),
      .match_irq_a_o(hit_a), .match_irq_b_o(hit_b), .irq_o
   );
   tec_pin_drv pins (.clk_i, .pin_a_o(pin_a), .pin_b_o(pin_b));

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic flag(input string nm, input logic e, g);
      chk(nm, {15'h0000, e}, {15'h0000, g});
   endtask

   task automatic rdchk(input string nm, input logic [3:0] a,
                        input logic [15:0] e);
      rd(a, c1);
      chk(nm, e, c1);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask

   // Bounded wait for a match pulse; n ends as the cycles waited
   task automatic wait_hit(input logic b_side);
      // Step off the edge so a pulse launched there is settled
      #1;
      n = 0;
      while ((b_side ? hit_b : hit_a) !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #400000;
      errors++;
      results;
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("count", `TEC_A_CNT, 16'h0000);
      rdchk("control 0", `TEC_A_CTL0, `TEC_CTL0_RST);
      rdchk("reg a", `TEC_A_CCR_A, `TEC_CCR_RST);
      rdchk("reg b", `TEC_A_CCR_B, `TEC_CCR_RST);
      for (int a = 12; a < 16; a++)
         rdchk("unmapped", a[3:0], 16'h0000);
      $display("Test reset values done");

      // Zero buffers must match on the very first step
      wr(`TEC_A_CTL0, 16'h0080);
      wait_hit(1'b0);
      flag("buffer a at reset", 1'b1, hit_a);
      flag("buffer b at reset", 1'b1, hit_b);
      for (int s = 0; s < 8; s++) begin
         wr(`TEC_A_CTL0, 16'h0000);
         rdchk("stopped count", `TEC_A_CNT, 16'h0000);
         wr(`TEC_A_CTL0, 16'h0080 | s[15:0]);
         cyc(4 << s);
         rd(`TEC_A_CNT, c0);
         cyc((4 << s) - 2);
         rd(`TEC_A_CNT, c1);
         chk("steps per four periods", 16'h0004, c1 - c0);
      end
      $display("Test prescaled counting done");

      wr(`TEC_A_CTL0, 16'h0000);
      wr(`TEC_A_CCR_A, 16'h0005);
      wr(`TEC_A_CCR_B, 16'h0009);
      wr(`TEC_A_MASK, 16'h0003);
      wr(`TEC_A_OUTCTL, 16'h0005);
      wr(`TEC_A_STAT, 16'h0007);
      rdchk("reg a", `TEC_A_CCR_A, 16'h0005);
      wr(`TEC_A_CTL0, 16'h0080);
      wait_hit(1'b0);
      flag("match a", 1'b1, hit_a);
      wait_hit(1'b1);
      chk("gap a to b", 16'h0004, n[15:0]);
      flag("irq level", 1'b1, irq_o);
      cyc(3);
      flag("output a", 1'b1, out_a);
      flag("output b", 1'b1, out_b);
      rdchk("status", `TEC_A_STAT, 16'h0003);
      wr(`TEC_A_STAT, 16'h0003);
      cyc(2);
      flag("irq cleared", 1'b0, irq_o);
      wr(`TEC_A_MASK, 16'h0000);
      wr(`TEC_A_CTL0, 16'h0000);
      cyc(2);
      flag("output a stopped", 1'b0, out_a);
      wr(`TEC_A_CTL0, 16'h0080);
      cyc(15);
      flag("irq masked", 1'b0, irq_o);
      rdchk("status masked", `TEC_A_STAT, 16'h0003);
      wr(`TEC_A_MASK, 16'h0003);
      cyc(2);
      flag("irq unmasked", 1'b1, irq_o);
      wr(`TEC_A_STAT, 16'h0007);
      $display("Test compare match done");

      wr(`TEC_A_CTL1, 16'h0006);
      wr(`TEC_A_EDGE_A, 16'h0003);
      wr(`TEC_A_NFC_A, 16'h0001);
      wr(`TEC_A_STAT, 16'h0007);
      pins.drive(1'b1, 1'b0, 1);
      pins.drive(1'b0, 1'b0, 8);
      rdchk("filtered glitch", `TEC_A_STAT, 16'h0000);
      wr(`TEC_A_NFC_A, 16'h0000);
      wr(`TEC_A_STAT, 16'h0007);
      pins.drive(1'b1, 1'b0, 1);
      pins.drive(1'b0, 1'b0, 8);
      rdchk("raw glitch", `TEC_A_STAT, 16'h0001);
      for (int e = 0; e < 4; e++) begin
         wr(`TEC_A_EDGE_B, e[15:0]);
         wr(`TEC_A_STAT, 16'h0007);
         pins.drive(1'b0, 1'b1, 8);
         rdchk("rise b", `TEC_A_STAT, {14'h0000, e[0], 1'b0});
         wr(`TEC_A_STAT, 16'h0007);
         pins.drive(1'b0, 1'b0, 8);
         rdchk("fall b", `TEC_A_STAT, {14'h0000, e[1], 1'b0});
      end
      $display("Test capture edges done");

      wr(`TEC_A_CTL0, 16'h0000);
      wr(`TEC_A_CTL1, 16'h0001);
      wr(`TEC_A_EDGE_A, 16'h0004);
      wr(`TEC_A_CTL0, 16'h0080);
      cyc(4);
      repeat (3) begin
         pins.drive(1'b1, 1'b0, 4);
         pins.drive(1'b0, 1'b0, 4);
      end
      cyc(4);
      rdchk("event count", `TEC_A_CNT, 16'h0002);
      $display("Test event count done");

      // Trigger mode: counter idles at all ones until an input A edge
      wr(`TEC_A_CTL0, 16'h0000);
      wr(`TEC_A_CTL1, 16'h0008);
      wr(`TEC_A_OUTCTL, 16'h0003);
      wr(`TEC_A_CTL0, 16'h0080);
      cyc(4);
      flag("output a level", 1'b1, out_a);
      flag("output b off", 1'b0, out_b);
      rdchk("trigger wait", `TEC_A_CNT, 16'hffff);
      pins.drive(1'b1, 1'b0, 4);
      rdchk("trigger start", `TEC_A_CNT, 16'h0001);
      $display("Test external trigger done");
      results;
   end
endmodule
